//--- hw/cpm_pkg.sv
package cpm_pkg;
  localparam int          DW       = 8;
  localparam int          AW       = 13;
  // stack window
  localparam logic [12:0] SP_RST   = 13'h007f;
  localparam logic [6:0]  SP_HI    = 7'h01;
  localparam logic [12:0] STK_LO   = 13'h0040;
  localparam logic [12:0] STK_HI   = 13'h007f;
  localparam logic [2:0]  INT_LAST = 3'h4;
  localparam logic [2:0]  CALL_LAST = 3'h1;
  localparam logic [2:0]  RTS_BASE = 3'h1;
  // memory map, 8192 bytes
  localparam logic [12:0] IO_END   = 13'h000f;
  localparam logic [12:0] RAM_END  = 13'h007f;
  localparam logic [12:0] ROM_END  = 13'h08af;
  localparam logic [12:0] VEC_BASE = 13'h1ff6;
  // register bus word offsets
  localparam logic [7:0]  OFS_ACC  = 8'h00;
  localparam logic [7:0]  OFS_IDX  = 8'h04;
  localparam logic [7:0]  OFS_PC   = 8'h08;
  localparam logic [7:0]  OFS_SP   = 8'h0c;
  localparam logic [7:0]  OFS_FLG  = 8'h10;
  localparam logic [7:0]  OFS_STAT = 8'h14;
  // flag register bit positions
  localparam int          FL_C     = 0;
  localparam int          FL_Z     = 1;
  localparam int          FL_N     = 2;
  localparam int          FL_I     = 3;
  localparam int          FL_H     = 4;
  localparam logic [4:0]  FLG_RST  = 5'h08;

  typedef enum logic [3:0] {
    OP_NOP, OP_CALL, OP_INT, OP_SWI, OP_RTI, OP_RTS, OP_RSP, OP_SEI, OP_CLI
  } cpm_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PUSH = 2'b01, ST_PULL = 2'b11, ST_DRAIN = 2'b10
  } cpm_st_t;
  typedef enum logic [1:0] {DST_NONE, DST_ACC, DST_IDX} cpm_dst_t;
  typedef enum logic [1:0] {ALU_PASS, ALU_ADD, ALU_SUB} cpm_alu_op_t;
  typedef enum logic [2:0] {RG_IO, RG_RAM, RG_ROM, RG_VEC, RG_UNUSED} cpm_region_t;
  // stacked byte slots, interrupt push order
  typedef enum logic [2:0] {B_PCL, B_PCH, B_IDX, B_ACC, B_FLG} cpm_slot_t;

  typedef struct packed {
    logic        wr;
    cpm_dst_t    dst;
    cpm_alu_op_t op;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic        cin;
    logic        upd_h;
    logic        upd_nz;
    logic        upd_c;
    logic        c_in;
  } cpm_alu_t;

  typedef struct packed {
    logic        load;
    logic        inc;
    logic [12:0] val;
  } cpm_pc_t;
endpackage

//--- hw/cpm_core.sv
// Notes on behaviour
// - 8-bit accumulator for arithmetic results
// - 8-bit index register, also data store
// - 13-bit counter holds next instruction address
// - 13-bit stack pointer addresses next free
// - stack address upper seven bits are 0000001
// - stack addresses stay within 0x40..0x7f
// - push decrements, pull increments stack pointer
// - reset or stack reset loads 0x7f
// - stack wraps bottom to top silently
// - call pushes two bytes, interrupt five
// - push low, high, rest; pull reversed
// - five-bit flags reflect last instruction
// - half carry from bit 3 on add
// - mask flag blocks external and timer interrupts
// - masked interrupt pends until mask clears
// - negative flag copies result bit 7
// - zero flag set on zero result
// - carry from alu, shifts, rotates, bit tests; the core has no shifts, rotates or bit tests and takes carry from the alu only
// - decode 8192 byte space, 13 bits
// - low 128: ports, timer, RAM; ROM follows
// - top ten addresses hold vectors
// - unused reads harmless, disturb nothing
// - reset sets interrupt mask flag
//
// The address map and register access over Wishbone were left to the implementer.
module cpm_core (
  // clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_b_in,
  // wishbone slave
  input  wire logic                 wb_cyc_in,
  input  wire logic                 wb_stb_in,
  input  wire logic                 wb_we_in,
  input  wire logic [7:0]           wb_adr_in,
  input  wire logic [3:0]           wb_sel_in,
  input  wire logic [31:0]          wb_dat_in,
  output logic      [31:0]          wb_dat_out,
  output logic                      wb_ack_out,
  // sequencer side
  input  wire cpm_pkg::cpm_op_t     op_in,
  input  wire cpm_pkg::cpm_alu_t    alu_in,
  input  wire cpm_pkg::cpm_pc_t     pc_in,
  input  wire logic                 irq_ext_in,
  input  wire logic                 irq_tmr_in,
  output logic                      busy_out,
  output logic                      int_req_out,
  output logic                      int_ext_out,
  output logic      [7:0]           acc_out,
  output logic      [7:0]           idx_out,
  output logic      [12:0]          pc_out,
  output logic      [12:0]          sp_out,
  output logic      [4:0]           flags_out,
  // memory side
  output logic      [12:0]          mem_addr_out,
  output logic      [7:0]           mem_wdata_out,
  output logic                      mem_we_out,
  output logic                      mem_re_out,
  input  wire logic [7:0]           mem_rdata_in,
  input  wire logic [12:0]          dec_addr_in,
  output cpm_pkg::cpm_region_t      region_out
);
  cpm_pkg::cpm_st_t  st_ff;
  cpm_pkg::cpm_st_t  nxt_st;
  logic [2:0]        k_ff;
  logic [2:0]        last_ff;
  logic              kint_ff;
  logic [2:0]        rd_slot_ff;
  logic              pend_e_ff;
  logic              pend_t_ff;
  logic              accept;
  logic              push_end;
  logic              wb_wr;
  logic [7:0]        alu_res;
  logic              alu_c;
  logic              alu_h;
  logic [8:0]        sum9;
  logic [4:0]        sum5;

  assign accept   = (st_ff == cpm_pkg::ST_IDLE) && (op_in != cpm_pkg::OP_NOP);
  assign push_end = (st_ff == cpm_pkg::ST_PUSH) && (k_ff == last_ff);
  // write takes effect on the edge where the master sees ack
  assign wb_wr    = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;

  function automatic logic [12:0] stk(input logic [5:0] lo);
    stk = {cpm_pkg::SP_HI, lo};
  endfunction

  function automatic logic [7:0] push_byte(input logic [2:0] s);
    case (s)
      cpm_pkg::B_PCL: push_byte = pc_out[7:0];
      cpm_pkg::B_PCH: push_byte = {3'h0, pc_out[12:8]};
      cpm_pkg::B_IDX: push_byte = idx_out;
      cpm_pkg::B_ACC: push_byte = acc_out;
      default:        push_byte = {3'h0, flags_out};
    endcase
  endfunction

  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    case (alu_in.op)
      cpm_pkg::ALU_ADD: begin
        sum9 = {1'b0, alu_in.opa} + {1'b0, alu_in.opb} + {8'h00, alu_in.cin};
        sum5 = {1'b0, alu_in.opa[3:0]} + {1'b0, alu_in.opb[3:0]} + {4'h0, alu_in.cin};
      end
      cpm_pkg::ALU_SUB: begin
        sum9 = {1'b0, alu_in.opa} - {1'b0, alu_in.opb} - {8'h00, alu_in.cin};
      end
      default: begin
        sum9 = {alu_in.c_in, alu_in.opa};
      end
    endcase
    alu_res = sum9[7:0];
    alu_c   = sum9[8];
    alu_h   = sum5[4];
  end

  // stacking sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      cpm_pkg::ST_IDLE: begin
        if (op_in == cpm_pkg::OP_CALL || op_in == cpm_pkg::OP_INT || op_in == cpm_pkg::OP_SWI) begin
          nxt_st = cpm_pkg::ST_PUSH;
        end else if (op_in == cpm_pkg::OP_RTI || op_in == cpm_pkg::OP_RTS) begin
          nxt_st = cpm_pkg::ST_PULL;
        end
      end
      cpm_pkg::ST_PUSH: if (k_ff == last_ff) nxt_st = cpm_pkg::ST_IDLE;
      cpm_pkg::ST_PULL: if (k_ff == last_ff) nxt_st = cpm_pkg::ST_DRAIN;
      default:          nxt_st = cpm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff    <= cpm_pkg::ST_IDLE;
      k_ff     <= 3'h0;
      last_ff  <= 3'h0;
      kint_ff  <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      busy_out <= (nxt_st != cpm_pkg::ST_IDLE);
      if (accept) begin
        k_ff    <= 3'h0;
        kint_ff <= (op_in != cpm_pkg::OP_CALL) && (op_in != cpm_pkg::OP_RTS);
        last_ff <= (op_in == cpm_pkg::OP_CALL || op_in == cpm_pkg::OP_RTS) ? cpm_pkg::CALL_LAST
                                                                          : cpm_pkg::INT_LAST;
      end else if (st_ff == cpm_pkg::ST_PUSH || st_ff == cpm_pkg::ST_PULL) begin
        k_ff <= k_ff + 3'h1;
      end
    end
  end

  // memory strobes
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_addr_out  <= cpm_pkg::SP_RST;
      mem_wdata_out <= 8'h00;
      mem_we_out    <= 1'b0;
      mem_re_out    <= 1'b0;
      rd_slot_ff    <= 3'h0;
    end else begin
      mem_we_out <= (st_ff == cpm_pkg::ST_PUSH);
      mem_re_out <= (st_ff == cpm_pkg::ST_PULL);
      if (st_ff == cpm_pkg::ST_PUSH) begin
        mem_addr_out  <= stk(sp_out[5:0]);
        mem_wdata_out <= push_byte(k_ff);
      end else if (st_ff == cpm_pkg::ST_PULL) begin
        mem_addr_out <= stk(sp_out[5:0] + 6'h01);
        rd_slot_ff   <= kint_ff ? (cpm_pkg::INT_LAST - k_ff) : (cpm_pkg::RTS_BASE - k_ff);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_out <= cpm_pkg::SP_RST;
    end else if (accept && op_in == cpm_pkg::OP_RSP) begin
      sp_out <= cpm_pkg::SP_RST;
    end else if (st_ff == cpm_pkg::ST_PUSH) begin
      sp_out <= stk(sp_out[5:0] - 6'h01);
    end else if (st_ff == cpm_pkg::ST_PULL) begin
      sp_out <= stk(sp_out[5:0] + 6'h01);
    end else if (wb_wr && wb_adr_in == cpm_pkg::OFS_SP && wb_sel_in[0]) begin
      sp_out <= stk(wb_dat_in[5:0]);
    end
  end

  // accumulator and index: pull, then alu, then bus
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_out <= 8'h00;
      idx_out <= 8'h00;
    end else if (mem_re_out) begin
      if (rd_slot_ff == cpm_pkg::B_ACC) acc_out <= mem_rdata_in;
      if (rd_slot_ff == cpm_pkg::B_IDX) idx_out <= mem_rdata_in;
    end else if (alu_in.wr && alu_in.dst != cpm_pkg::DST_NONE) begin
      if (alu_in.dst == cpm_pkg::DST_ACC) acc_out <= alu_res;
      if (alu_in.dst == cpm_pkg::DST_IDX) idx_out <= alu_res;
    end else if (wb_wr && wb_sel_in[0]) begin
      if (wb_adr_in == cpm_pkg::OFS_ACC) acc_out <= wb_dat_in[7:0];
      if (wb_adr_in == cpm_pkg::OFS_IDX) idx_out <= wb_dat_in[7:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_out <= 13'h0000;
    end else if (mem_re_out && rd_slot_ff == cpm_pkg::B_PCL) begin
      pc_out[7:0] <= mem_rdata_in;
    end else if (mem_re_out && rd_slot_ff == cpm_pkg::B_PCH) begin
      pc_out[12:8] <= mem_rdata_in[4:0];
    end else if (pc_in.load) begin
      pc_out <= pc_in.val;
    end else if (pc_in.inc) begin
      pc_out <= pc_out + 13'h0001;
    end else if (wb_wr && wb_adr_in == cpm_pkg::OFS_PC) begin
      if (wb_sel_in[0]) pc_out[7:0]  <= wb_dat_in[7:0];
      if (wb_sel_in[1]) pc_out[12:8] <= wb_dat_in[12:8];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags_out <= cpm_pkg::FLG_RST;
    end else if (mem_re_out && rd_slot_ff == cpm_pkg::B_FLG) begin
      flags_out <= mem_rdata_in[4:0];
    end else if (push_end && kint_ff) begin
      // masked only after the old flags are stacked
      flags_out[cpm_pkg::FL_I] <= 1'b1;
    end else if (accept && op_in == cpm_pkg::OP_SEI) begin
      flags_out[cpm_pkg::FL_I] <= 1'b1;
    end else if (accept && op_in == cpm_pkg::OP_CLI) begin
      flags_out[cpm_pkg::FL_I] <= 1'b0;
    end else if (alu_in.wr) begin
      if (alu_in.upd_h)  flags_out[cpm_pkg::FL_H] <= alu_h;
      if (alu_in.upd_nz) flags_out[cpm_pkg::FL_N] <= alu_res[7];
      if (alu_in.upd_nz) flags_out[cpm_pkg::FL_Z] <= (alu_res == 8'h00);
      if (alu_in.upd_c)  flags_out[cpm_pkg::FL_C] <= alu_c;
    end else if (wb_wr && wb_adr_in == cpm_pkg::OFS_FLG && wb_sel_in[0]) begin
      flags_out <= wb_dat_in[4:0];
    end
  end

  // pending latches, new request beats the clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_e_ff <= 1'b0;
      pend_t_ff <= 1'b0;
    end else begin
      pend_e_ff <= irq_ext_in | (pend_e_ff & ~(accept && op_in == cpm_pkg::OP_INT));
      pend_t_ff <= irq_tmr_in | (pend_t_ff & ~(accept && op_in == cpm_pkg::OP_INT && !pend_e_ff));
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_req_out <= 1'b0;
      int_ext_out <= 1'b0;
    end else begin
      int_req_out <= (pend_e_ff | pend_t_ff) & ~flags_out[cpm_pkg::FL_I] & ~accept;
      int_ext_out <= pend_e_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      region_out <= cpm_pkg::RG_IO;
    end else if (dec_addr_in <= cpm_pkg::IO_END) begin
      region_out <= cpm_pkg::RG_IO;
    end else if (dec_addr_in <= cpm_pkg::RAM_END) begin
      region_out <= cpm_pkg::RG_RAM;
    end else if (dec_addr_in <= cpm_pkg::ROM_END) begin
      region_out <= cpm_pkg::RG_ROM;
    end else if (dec_addr_in >= cpm_pkg::VEC_BASE) begin
      region_out <= cpm_pkg::RG_VEC;
    end else begin
      region_out <= cpm_pkg::RG_UNUSED;
    end
  end

  // wishbone slave, one wait state, unmapped reads return zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      case (wb_adr_in)
        cpm_pkg::OFS_ACC:  wb_dat_out <= {24'h000000, acc_out};
        cpm_pkg::OFS_IDX:  wb_dat_out <= {24'h000000, idx_out};
        cpm_pkg::OFS_PC:   wb_dat_out <= {19'h00000, pc_out};
        cpm_pkg::OFS_SP:   wb_dat_out <= {19'h00000, sp_out};
        cpm_pkg::OFS_FLG:  wb_dat_out <= {27'h0000000, flags_out};
        cpm_pkg::OFS_STAT: wb_dat_out <= {28'h0000000, int_req_out, pend_t_ff, pend_e_ff, busy_out};
        default:           wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_int_go;
    accept && (op_in == cpm_pkg::OP_INT || op_in == cpm_pkg::OP_SWI);
  endsequence
  sequence s_five_writes;
    mem_we_out [*5] ##1 !mem_we_out;
  endsequence

  property p_stk_hi;
    (mem_we_out || mem_re_out) |-> (mem_addr_out[12:6] == cpm_pkg::SP_HI);
  endproperty
  a_stk_hi: assert property (p_stk_hi) else $error("stack address upper bits wrong");
  property p_sp_range;
    (sp_out >= cpm_pkg::STK_LO) && (sp_out <= cpm_pkg::STK_HI);
  endproperty
  a_sp_range: assert property (p_sp_range) else $error("stack pointer out of window");
  property p_push_dec;
    mem_we_out |-> (mem_addr_out == $past(sp_out)) && (sp_out == stk($past(sp_out[5:0]) - 6'h01));
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not decrement");
  property p_rsp;
    (accept && op_in == cpm_pkg::OP_RSP) |=> (sp_out == cpm_pkg::SP_RST);
  endproperty
  a_rsp: assert property (p_rsp) else $error("stack reset missed");
  property p_int_five;
    s_int_go |-> ##2 s_five_writes;
  endproperty
  a_int_five: assert property (p_int_five) else $error("interrupt entry not five bytes");
  property p_pcl_first;
    s_int_go |-> ##2 (mem_wdata_out == $past(pc_out[7:0], 2));
  endproperty
  a_pcl_first: assert property (p_pcl_first) else $error("low counter byte not first");
  property p_mask_blocks;
    $past(flags_out[cpm_pkg::FL_I]) |-> !int_req_out;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("request while masked");
  property p_pend_serve;
    (pend_e_ff && !flags_out[cpm_pkg::FL_I] && !accept) |=> int_req_out;
  endproperty
  a_pend_serve: assert property (p_pend_serve) else $error("pending request lost");
  property p_zero;
    (alu_in.wr && alu_in.upd_nz && !mem_re_out && !accept && !push_end)
      |=> (flags_out[cpm_pkg::FL_Z] == ($past(alu_res) == 8'h00)) && (flags_out[cpm_pkg::FL_N] == $past(alu_res[7]));
  endproperty
  a_zero: assert property (p_zero) else $error("zero or sign flag wrong");
  property p_vec;
    (dec_addr_in >= cpm_pkg::VEC_BASE) |=> (region_out == cpm_pkg::RG_VEC);
  endproperty
  a_vec: assert property (p_vec) else $error("vector region missed");
endmodule

//--- tb/cpm_mem_model.sv
module cpm_mem_model (
  // clock
  input  wire logic        clk_in,
  // byte port from the block
  input  wire logic [12:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  output logic      [7:0]  rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];
  logic [7:0] last_q = 8'h00;
  // outside a read the line shows the inverse, so a late capture cannot pass
  assign rdata_out = re_in ? mem[addr_in] : ~last_q;
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    if (re_in) begin
      last_q <= mem[addr_in];
    end
  end
endmodule

//--- tb/cpu_programming_model_stack_tb.sv
module cpu_programming_model_stack_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic                 irq_ext_in, irq_tmr_in, busy_out, int_req_out, int_ext_out, mem_we_out, mem_re_out;
  logic [3:0]           wb_sel_in;
  logic [7:0]           wb_adr_in, acc_out, idx_out, mem_wdata_out, mem_rdata_in;
  logic [12:0]          pc_out, sp_out, mem_addr_out, dec_addr_in;
  logic [31:0]          wb_dat_in, wb_dat_out, rd;
  logic [4:0]           flags_out;
  cpm_pkg::cpm_op_t     op_in;
  cpm_pkg::cpm_alu_t    alu_in;
  cpm_pkg::cpm_pc_t     pc_in;
  cpm_pkg::cpm_region_t region_out;
  int                   error_cnt = 0;
  int                   comparisons = 0;

  cpm_core i_cpm_core (.sys_clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .op_in, .alu_in, .pc_in, .irq_ext_in, .irq_tmr_in, .busy_out,
    .int_req_out, .int_ext_out, .acc_out, .idx_out, .pc_out, .sp_out, .flags_out, .mem_addr_out,
    .mem_wdata_out, .mem_we_out, .mem_re_out, .mem_rdata_in, .dec_addr_in, .region_out);
  cpm_mem_model i_cpm_mem_model (.clk_in(sys_clk_in), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .we_in(mem_we_out), .re_in(mem_re_out), .rdata_out(mem_rdata_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic bail(input int n);
    if (n >= 16) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // every stack byte moved must stay in the stack window
  always @(posedge sys_clk_in) begin
    if (rst_b_in && (mem_we_out || mem_re_out)) begin
      check(mem_addr_out[12:6], 7'h01); // window bits
    end
  end

  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wd);
    int n;
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= wd;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 16);
    bail(n);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask

  task automatic run_op(input cpm_pkg::cpm_op_t o);
    int n;
    @(posedge sys_clk_in);
    op_in <= o;
    @(posedge sys_clk_in);
    op_in <= cpm_pkg::OP_NOP;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (busy_out !== 1'b0 && n < 16);
    bail(n);
    // the last stacked byte reaches memory one edge after busy drops
    @(posedge sys_clk_in);
  endtask

  task automatic alu(input cpm_pkg::cpm_dst_t d, input cpm_pkg::cpm_alu_op_t o, input logic [7:0] a,
                     input logic [7:0] b, input logic [2:0] upd);
    @(posedge sys_clk_in);
    alu_in <= '{1'b1, d, o, a, b, 1'b0, upd[2], upd[1], upd[0], 1'b0};
    @(posedge sys_clk_in);
    alu_in.wr <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic prog_step(input logic ld, input logic inc, input logic [12:0] v);
    @(posedge sys_clk_in);
    pc_in <= '{ld, inc, v};
    @(posedge sys_clk_in);
    pc_in <= '0;
    @(posedge sys_clk_in);
  endtask

  task automatic pulse(input bit tmr);
    @(posedge sys_clk_in);
    irq_ext_in <= !tmr;
    irq_tmr_in <= tmr;
    @(posedge sys_clk_in);
    irq_ext_in <= 1'b0;
    irq_tmr_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask

  task automatic t_regs();
    check({sp_out, flags_out}, {13'h007f, 5'h08}); // reset state
    wb(1'b1, cpm_pkg::OFS_ACC, 4'h1, 32'h0000_00a5);
    wb(1'b1, cpm_pkg::OFS_IDX, 4'h1, 32'h0000_003c);
    wb(1'b0, cpm_pkg::OFS_ACC, 4'hf, 32'h0);
    check(rd[7:0], 8'ha5); // accumulator readback
    wb(1'b0, cpm_pkg::OFS_SP, 4'hf, 32'h0);
    check(rd[12:0], 13'h007f); // pointer value
    wb(1'b0, cpm_pkg::OFS_FLG, 4'hf, 32'h0);
    check(rd[4:0], 5'h08); // flag readback
    wb(1'b0, 8'h18, 4'hf, 32'h0);
    check({acc_out, idx_out}, 16'ha53c); // state kept
  endtask

  task automatic t_alu();
    alu(cpm_pkg::DST_ACC, cpm_pkg::ALU_ADD, 8'h08, 8'h08, 3'b111);
    check({acc_out, flags_out}, {8'h10, 5'h18}); // half carry
    // no half carry update on subtract, so H must hold
    alu(cpm_pkg::DST_IDX, cpm_pkg::ALU_SUB, 8'h00, 8'h01, 3'b011);
    check({idx_out, flags_out}, {8'hff, 5'h1d}); // negative borrow
    alu(cpm_pkg::DST_ACC, cpm_pkg::ALU_ADD, 8'h80, 8'h80, 3'b111);
    check({acc_out, flags_out}, {8'h00, 5'h0b}); // zero and carry
    alu(cpm_pkg::DST_NONE, cpm_pkg::ALU_PASS, 8'h55, 8'h00, 3'b001);
    check({acc_out, flags_out}, {8'h00, 5'h0a}); // only carry moves
  endtask

  task automatic t_call();
    prog_step(1'b1, 1'b0, 13'h1abc);
    prog_step(1'b0, 1'b1, 13'h0000);
    check(pc_out, 13'h1abd); // load then step
    run_op(cpm_pkg::OP_CALL);
    check(sp_out, 13'h007d); // two bytes
    check({i_cpm_mem_model.mem[13'h7f], i_cpm_mem_model.mem[13'h7e][4:0]}, 13'h17ba); // low first
    wb(1'b1, cpm_pkg::OFS_PC, 4'h3, 32'h0);
    @(posedge sys_clk_in);
    check(pc_out, 13'h0); // bus write
    run_op(cpm_pkg::OP_RTS);
    check({sp_out, pc_out}, {13'h007f, 13'h1abd}); // pulled back
    wb(1'b1, cpm_pkg::OFS_SP, 4'h1, 32'h0);
    @(posedge sys_clk_in);
    check(sp_out, 13'h0040); // bottom limit
    run_op(cpm_pkg::OP_CALL);
    check({sp_out, i_cpm_mem_model.mem[13'h40]}, {13'h007e, 8'hbd}); // wrap to top
    check(i_cpm_mem_model.mem[13'h7f][4:0], 5'h1a); // overwrite
    run_op(cpm_pkg::OP_RSP);
    check(sp_out, 13'h007f); // stack reset op
  endtask

  task automatic t_int();
    logic [7:0] e [5] = '{8'hbd, 8'h1a, 8'h22, 8'h11, 8'h02};
    run_op(cpm_pkg::OP_CLI);
    wb(1'b1, cpm_pkg::OFS_ACC, 4'h1, 32'h11);
    wb(1'b1, cpm_pkg::OFS_IDX, 4'h1, 32'h22);
    pulse(1'b0);
    check({int_req_out, int_ext_out}, 2'b11); // unmasked request
    run_op(cpm_pkg::OP_INT);
    check({sp_out, flags_out}, {13'h007a, 5'h0a}); // five bytes, masked
    for (int k = 0; k < 5; k++) begin
      check(i_cpm_mem_model.mem[13'h7f - k] & ((k == 1 || k == 4) ? 8'h1f : 8'hff), e[k]); // order
    end
    check({int_req_out, int_ext_out}, 2'b00); // request served
    wb(1'b1, cpm_pkg::OFS_ACC, 4'h1, 32'h0);
    wb(1'b1, cpm_pkg::OFS_IDX, 4'h1, 32'h0);
    wb(1'b1, cpm_pkg::OFS_PC, 4'h3, 32'h0);
    wb(1'b1, cpm_pkg::OFS_FLG, 4'h1, 32'h1f);
    run_op(cpm_pkg::OP_RTI);
    check({acc_out, idx_out, flags_out}, {8'h11, 8'h22, 5'h02}); // reverse pull
    check({pc_out, sp_out}, {13'h1abd, 13'h007f}); // counter restored
  endtask

  task automatic t_masked();
    run_op(cpm_pkg::OP_SEI);
    pulse(1'b1);
    check(int_req_out, 1'b0); // timer blocked
    run_op(cpm_pkg::OP_SWI);
    wb(1'b0, cpm_pkg::OFS_STAT, 4'hf, 32'h0);
    check(rd[3:0], 4'h4); // held pending
    run_op(cpm_pkg::OP_RSP);
    run_op(cpm_pkg::OP_CLI);
    repeat (2) @(posedge sys_clk_in);
    check(int_req_out, 1'b1); // served on clear
    run_op(cpm_pkg::OP_INT);
    wb(1'b0, cpm_pkg::OFS_STAT, 4'hf, 32'h0);
    check(rd[3:0], 4'h0); // pending cleared
  endtask

  task automatic t_region();
    logic [12:0] ra [10] = '{13'h0, 13'hf, 13'h10, 13'h7f, 13'h80, 13'h8af, 13'h8b0, 13'h1ff5, 13'h1ff6, 13'h1fff};
    cpm_pkg::cpm_region_t rr [10] = '{cpm_pkg::RG_IO, cpm_pkg::RG_IO, cpm_pkg::RG_RAM, cpm_pkg::RG_RAM,
      cpm_pkg::RG_ROM, cpm_pkg::RG_ROM, cpm_pkg::RG_UNUSED, cpm_pkg::RG_UNUSED, cpm_pkg::RG_VEC, cpm_pkg::RG_VEC};
    foreach (ra[k]) begin
      @(posedge sys_clk_in);
      dec_addr_in <= ra[k];
      repeat (2) @(posedge sys_clk_in);
      check(region_out, rr[k]); // address map
    end
  endtask

  initial begin
    rst_b_in = 1'b0;
    {wb_cyc_in, wb_stb_in, wb_we_in, irq_ext_in, irq_tmr_in} = '0;
    {wb_sel_in, wb_adr_in, wb_dat_in, dec_addr_in} = '0;
    op_in = cpm_pkg::OP_NOP;
    alu_in = '0;
    pc_in = '0;
    repeat (12) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    @(posedge sys_clk_in);
    t_regs();
    t_alu();
    t_call();
    t_int();
    t_masked();
    t_region();
    give_verdict();
  end
endmodule
